// ==== bench/usrt_core_test.sv ====
// Purpose: self-checking bench for the serial port block
// Assumes: 40 MHz clk, peer model on the serial pins
// Notes: registers are reached through apb tasks only
`timescale 1ns/1ps
`default_nettype none
`include "usrt_cfg.svh"
module usrt_core_test;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, sclk, sdin, sdout, perr, oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, txcs;
	logic [7:0] rx, d;
	logic [9:0] frame;
	int error_cnt = 0, comparisons = 0, cycles = 0, fcnt, cnt;

	usrt_core i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ser_clk_in(sclk), .ser_data_in(sdin), .ser_data_out(sdout),
		.ser_data_oe(oe), .irq(irq), .wake());
	usrt_peer i_peer (.line_in(sdout), .clk_out(sclk), .data_out(sdin), .frame(frame),
		.frame_cnt(fcnt));

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic finish_test;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; the extra edge keeps back-to-back calls apart
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) error_cnt++;
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		check(r, exp);
	endtask : rd

	task automatic waitf(input int n);
		wait (fcnt >= n);
		@(posedge clk);
	endtask : waitf

	// --------------------------------------------------------------
	// clock, hang guard, main sequence
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// about 4600 cycles expected; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test;
		end
	end

	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(`USRT_OFS_TXCS, 32'h0000_0002);
		rd(`USRT_OFS_BAUD, 32'h0000_0000);
		apb(1'b0, 12'h024, '0);
		check(32'(perr), 32'h0000_0001);
		wr(`USRT_OFS_RXCS, 32'h0000_0080);
		// k=0: divisor 1 at x16, k=1: divisor 0 at x64 with nine bits
		for (int k = 0; k < 2; k++) begin
			wr(`USRT_OFS_BAUD, k ? 32'h0000_0000 : 32'h0000_0001);
			txcs = k ? 32'h0000_0060 : 32'h0000_0024;
			wr(`USRT_OFS_TXCS, txcs);
			rd(`USRT_OFS_FLAGS, 32'h0000_0010);
			check(32'(irq), 32'h0000_0000);
			check(32'(oe), 32'h0000_0001);
			wr(`USRT_OFS_ENABLES, 32'h0000_0010);
			@(posedge clk);
			check(32'(irq), 32'h0000_0001);
			wr(`USRT_OFS_ENABLES, 32'h0000_0000);
			i_peer.bit_ns = (k + 1) * 800;
			i_peer.nine = k[0];
			d = k ? 8'h3c : 8'ha5;
			cnt = fcnt;
			wr(`USRT_OFS_TXBUF, 32'(d));
			wr(`USRT_OFS_TXBUF, 32'(~d));
			rd(`USRT_OFS_FLAGS, 32'h0000_0000);
			rd(`USRT_OFS_TXCS, txcs);
			for (int j = 0; j < 2; j++) begin
				waitf(cnt + j + 1);
				check(32'(frame), {22'b0, k ? 2'b10 : 2'b01, j ? ~d : d});
			end
			repeat (64) @(posedge clk);
			wr(`USRT_OFS_FLAGS, 32'h0000_0000);
			rd(`USRT_OFS_FLAGS, 32'h0000_0010);
			rd(`USRT_OFS_TXCS, txcs | 32'h0000_0002);
		end
		// asleep the async side must not move
		cnt = fcnt;
		wr(`USRT_OFS_SLEEP, 32'h0000_0001);
		wr(`USRT_OFS_TXBUF, 32'h0000_0055);
		repeat (1300) @(posedge clk);
		check(32'(fcnt), 32'(cnt));
		wr(`USRT_OFS_SLEEP, 32'h0000_0000);
		waitf(cnt + 1);
		check(32'(frame), 32'h0000_0255);
		// let the stop bit finish before the mode changes under it
		repeat (64) @(posedge clk);
		// sync slave: two words queued, receive armed, then sleep
		wr(`USRT_OFS_TXCS, 32'h0000_0030);
		wr(`USRT_OFS_ENABLES, 32'h0000_0020);
		wr(`USRT_OFS_TXBUF, 32'h0000_003c);
		wr(`USRT_OFS_TXBUF, 32'h0000_0081);
		rd(`USRT_OFS_FLAGS, 32'h0000_0000);
		wr(`USRT_OFS_RXCS, 32'h0000_0090);
		wr(`USRT_OFS_SLEEP, 32'h0000_0001);
		i_peer.xfer(8'h5a, rx);
		check(32'(rx), 32'h0000_003c);
		repeat (8) @(posedge clk);
		rd(`USRT_OFS_FLAGS, 32'h0000_0030);
		check(32'(irq), 32'h0000_0001);
		rd(`USRT_OFS_SLEEP, 32'h0000_0000);
		rd(`USRT_OFS_RXBUF, 32'h0000_005a);
		@(posedge clk);
		check(32'(irq), 32'h0000_0000);
		i_peer.xfer(8'hc3, rx);
		check(32'(rx), 32'h0000_0081);
		repeat (8) @(posedge clk);
		i_peer.xfer(8'h0f, rx);
		repeat (8) @(posedge clk);
		rd(`USRT_OFS_RXCS, 32'h0000_0092);
		wr(`USRT_OFS_RXCS, 32'h0000_0080);
		rd(`USRT_OFS_RXCS, 32'h0000_0080);
		finish_test;
	end
endmodule : usrt_core_test
`default_nettype wire

// ==== bench/usrt_peer.sv ====
// Purpose: remote serial node: async frame catcher and sync shift clock master
// Assumes: link clock period 200 ns, clock stands low between words
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module usrt_peer (
	input wire logic line_in,
	output logic clk_out,
	output logic data_out,
	output logic [9:0] frame,
	output int frame_cnt
);
	int bit_ns = 800;
	logic nine = 1'b0;

	initial begin
		clk_out = 1'b0;
		data_out = 1'b1;
		frame = '0;
		frame_cnt = 0;
	end

	// --------------------------------------------------------------
	// async catcher
	// --------------------------------------------------------------
	// mid-bit sampling, so a small rate error does not slip a bit
	always begin
		@(negedge line_in);
		#(bit_ns / 2);
		if (line_in === 1'b0) begin
			frame = '0;
			for (int i = 0; i < (nine ? 10 : 9); i++) begin
				#(bit_ns);
				frame[i] = line_in;
			end
			frame_cnt++;
		end
	end

	// --------------------------------------------------------------
	// sync word as clock master
	// --------------------------------------------------------------
	// data moves with the falling clock, both sides sample on rising
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			data_out = tx[i];
			#100 clk_out = 1'b1;
			rx[i] = line_in;
			#100 clk_out = 1'b0;
		end
		#100 data_out = ~tx[7];
	endtask : xfer
endmodule : usrt_peer
`default_nettype wire

// ==== rtl/usrt_cfg.svh ====
// Purpose: register offsets, field positions, reset values for the serial port block
// Assumes: 32-bit apb, one register per aligned word
// Notes: definitions only
`ifndef USRT_CFG_SVH
`define USRT_CFG_SVH
`define USRT_OFS_FLAGS 12'h000
`define USRT_OFS_ENABLES 12'h004
`define USRT_OFS_PRIORITY 12'h008
`define USRT_OFS_RXCS 12'h00c
`define USRT_OFS_TXBUF 12'h010
`define USRT_OFS_TXCS 12'h014
`define USRT_OFS_BAUD 12'h018
`define USRT_OFS_RXBUF 12'h01c
`define USRT_OFS_SLEEP 12'h020
// flag / enable bit positions
`define USRT_B_RC 5
`define USRT_B_TX 4
// transmit control/status fields
`define USRT_B_CLOCK_SOURCE_SELECT 7
`define USRT_B_TX9 6
`define USRT_B_TRANSMIT_ENABLE 5
`define USRT_B_SYNC 4
`define USRT_B_ADDRESS_DETECT_ENABLE 3
`define USRT_B_HIGH_SPEED_BAUD_SELECT 2
`define USRT_B_SHIFT_EMPTY_STATUS 1
`define USRT_B_TRANSMIT_NINTH_BIT 0
// receive control/status fields
`define USRT_B_SERIAL_PORT_ENABLE 7
`define USRT_B_RX9 6
`define USRT_B_SINGLE_RECEIVE_ENABLE 5
`define USRT_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USRT_B_FRAMING_ERROR_FLAG 2
`define USRT_B_OVERRUN_ERROR_FLAG 1
`define USRT_B_RECEIVED_NINTH_BIT 0
`define USRT_RST_TXCS 8'h02
`define USRT_RST_ZERO 8'h00
`define USRT_OVS_LO 7'd16
`define USRT_OVS_HI 7'd64
`endif

// ==== rtl/usrt_core.sv ====
// Purpose: async transmitter, sync slave transmit/receive, apb registers
// Assumes: clk 40 MHz, link clock sampled as an ordinary input
// Notes: async receiver and sync master are not present
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usrt_cfg.svh"
module usrt_core
	import usrt_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ser_clk_in,
	input wire logic ser_data_in,
	output logic ser_data_out,
	output logic ser_data_oe,
	output logic irq,
	output logic wake
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] flags_r, enables, priority_r, rxcs, txbuf, txcs, baud, rxbuf;
	logic sleep_r, buf_full, tsr_empty;
	logic [8:0] transmit_shift_register;
	logic [3:0] bitcnt;
	usrt_tx_e st;
	logic [6:0] ovs;
	logic [7:0] brg_cnt;
	logic [5:0] tick_cnt;
	logic [2:0] ck_sync, dat_sync;
	logic [8:0] receive_shift_register;
	logic [3:0] rcnt;
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire acc = psel & penable;
	// writes land only at the edge where pready is seen high, never twice per access
	wire wr = acc & pwrite & pready;
	// the shift register has no offset of its own, so it stays out of this map
	wire mapped = (paddr[11:6] == 6'd0) && (paddr[5:2] <= 4'd8) && (paddr[1:0] == 2'd0);
	wire wr_txbuf = wr && paddr == `USRT_OFS_TXBUF;
	wire wr_txcs = wr && paddr == `USRT_OFS_TXCS;
	wire wr_rxcs = wr && paddr == `USRT_OFS_RXCS;
	wire sync_mode = txcs[`USRT_B_SYNC];
	wire serial_port_enable = rxcs[`USRT_B_SERIAL_PORT_ENABLE];
	wire transmit_enable = txcs[`USRT_B_TRANSMIT_ENABLE];
	wire slave = sync_mode & ~txcs[`USRT_B_CLOCK_SOURCE_SELECT];
	wire async_run = serial_port_enable & ~sync_mode & ~sleep_r;
	wire transmit_enable_rise = wr_txcs & pwdata[`USRT_B_TRANSMIT_ENABLE] & ~transmit_enable;
	wire nine_tx = txcs[`USRT_B_TX9];
	wire [3:0] last_bit = nine_tx ? 4'd8 : 4'd7;
	// transmit gating and buffer move, needed early by the baud restart
	wire tx_active = transmit_enable & serial_port_enable & (slave | async_run);
	wire load = tx_active && st == TX_IDLE && buf_full;
	// external clock edges, after two-stage synchroniser
	wire ck_rise = ck_sync[1] & ~ck_sync[2];
	wire ck_fall = ~ck_sync[1] & ck_sync[2];
	// ----------------------------------------------------------------
	// baud generator: divisor+1 clocks per sample tick
	// ----------------------------------------------------------------
	wire brg_tick = async_run && brg_cnt == 8'd0;
	assign ovs = txcs[`USRT_B_HIGH_SPEED_BAUD_SELECT] ? `USRT_OVS_LO : `USRT_OVS_HI;
	wire bit_tick = brg_tick && {1'b0, tick_cnt} == ovs - 7'd1;
	// tick counter lives in the brg process so it resets with the port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			brg_cnt <= 8'h00;
			tick_cnt <= 6'd0;
		end else if (!async_run) begin
			brg_cnt <= 8'h00;
			tick_cnt <= 6'd0;
		end else if (load) begin
			// restart on load: a free-running tick would clip the start bit
			brg_cnt <= baud;
			tick_cnt <= 6'd0;
		end else if (brg_tick) begin
			brg_cnt <= baud;
			tick_cnt <= bit_tick ? 6'd0 : tick_cnt + 6'd1;
		end else begin
			brg_cnt <= brg_cnt - 8'd1;
		end
	end
	// synchronisers: first stage read only by the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_sync <= 3'b000;
			dat_sync <= 3'b111;
		end else begin
			ck_sync <= {ck_sync[1:0], ser_clk_in};
			dat_sync <= {dat_sync[1:0], ser_data_in};
		end
	end
	// ----------------------------------------------------------------
	// transmitter: load happens in a single cycle when idle and buffer full
	// ----------------------------------------------------------------
	wire slave_shift = slave & ck_fall; // data changes on falling edge
	wire adv = sync_mode ? slave_shift : bit_tick;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= TX_IDLE;
			transmit_shift_register <= 9'd0;
			bitcnt <= 4'd0;
			ser_data_out <= 1'b1;
		end else if (!tx_active) begin
			st <= TX_IDLE;
			ser_data_out <= 1'b1;
		end else begin
			case (st)
				TX_IDLE: begin
					if (load) begin
						bitcnt <= 4'd0;
						if (sync_mode) begin
							// first bit must stand before the master's first rising edge
							ser_data_out <= txbuf[0];
							transmit_shift_register <= {1'b0, txcs[`USRT_B_TRANSMIT_NINTH_BIT], txbuf[7:1]};
							st <= TX_DATA;
						end else begin
							transmit_shift_register <= {txcs[`USRT_B_TRANSMIT_NINTH_BIT], txbuf};
							ser_data_out <= 1'b0;
							st <= TX_START;
						end
					end
				end
				TX_START: if (adv) begin
					ser_data_out <= transmit_shift_register[0];
					transmit_shift_register <= transmit_shift_register >> 1;
					st <= TX_DATA;
				end
				TX_DATA: if (adv) begin
					if (sync_mode) begin
						ser_data_out <= transmit_shift_register[0];
						transmit_shift_register <= transmit_shift_register >> 1;
						bitcnt <= bitcnt + 4'd1;
						if (bitcnt == last_bit)
							st <= TX_IDLE;
					end else if (bitcnt == last_bit) begin
						ser_data_out <= 1'b1;
						st <= TX_STOP;
					end else begin
						ser_data_out <= transmit_shift_register[0];
						transmit_shift_register <= transmit_shift_register >> 1;
						bitcnt <= bitcnt + 4'd1;
					end
				end
				TX_STOP: if (adv)
					st <= TX_IDLE;
				default: st <= TX_IDLE;
			endcase
		end
	end
	// shift-empty and buffer occupancy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_full <= 1'b0;
			tsr_empty <= 1'b1;
		end else begin
			buf_full <= wr_txbuf ? 1'b1 : (load ? 1'b0 : buf_full);
			tsr_empty <= (st == TX_IDLE) & ~load;
		end
	end
	// ----------------------------------------------------------------
	// slave receiver: sample on rising external clock edge
	// ----------------------------------------------------------------
	wire continuous_receive_enable = rxcs[`USRT_B_CONTINUOUS_RECEIVE_ENABLE];
	wire rx_on = serial_port_enable & slave & continuous_receive_enable;
	wire [3:0] rx_last = rxcs[`USRT_B_RX9] ? 4'd8 : 4'd7;
	wire rx_done = rx_on && ck_rise && rcnt == rx_last;
	wire rd_rxbuf = acc & ~pwrite & pready & (paddr == `USRT_OFS_RXBUF);
	wire [8:0] rx_word = rxcs[`USRT_B_RX9] ? {dat_sync[1], receive_shift_register[8:1]} : {1'b0, dat_sync[1], receive_shift_register[8:2]};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			receive_shift_register <= 9'd0;
			rcnt <= 4'd0;
		end else if (!rx_on) begin
			rcnt <= 4'd0;
		end else if (ck_rise) begin
			receive_shift_register <= {dat_sync[1], receive_shift_register[8:1]};
			rcnt <= rx_done ? 4'd0 : rcnt + 4'd1;
		end
	end
	// ----------------------------------------------------------------
	// flags: set beats clear
	// ----------------------------------------------------------------
	wire set_tx = load | transmit_enable_rise;
	wire rc_full = flags_r[`USRT_B_RC];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= `USRT_RST_ZERO;
		end else begin
			// software writes to the flag register leave the tx bit alone
			if (set_tx)
				flags_r[`USRT_B_TX] <= 1'b1;
			else if (wr_txbuf)
				flags_r[`USRT_B_TX] <= 1'b0;
			if (rx_done)
				flags_r[`USRT_B_RC] <= 1'b1;
			else if (rd_rxbuf)
				flags_r[`USRT_B_RC] <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enables <= `USRT_RST_ZERO;
			priority_r <= `USRT_RST_ZERO;
			rxcs <= `USRT_RST_ZERO;
			txbuf <= `USRT_RST_ZERO;
			txcs <= `USRT_RST_TXCS;
			baud <= `USRT_RST_ZERO;
			rxbuf <= `USRT_RST_ZERO;
			sleep_r <= 1'b0;
		end else begin
			if (wr && paddr == `USRT_OFS_ENABLES)
				enables <= {1'b0, pwdata[6:0]};
			if (wr && paddr == `USRT_OFS_PRIORITY)
				priority_r <= {1'b0, pwdata[6:0]};
			if (wr && paddr == `USRT_OFS_BAUD)
				baud <= pwdata[7:0];
			if (wr_txbuf)
				txbuf <= pwdata[7:0];
			if (wr && paddr == `USRT_OFS_SLEEP)
				sleep_r <= pwdata[0];
			else if (wake)
				sleep_r <= 1'b0;
			if (wr_txcs)
				txcs <= {pwdata[7:2], txcs[`USRT_B_SHIFT_EMPTY_STATUS], pwdata[0]};
			txcs[`USRT_B_SHIFT_EMPTY_STATUS] <= tsr_empty;
			if (wr_rxcs) begin
				rxcs[7:4] <= pwdata[7:4];
				if (!pwdata[`USRT_B_CONTINUOUS_RECEIVE_ENABLE])
					rxcs[`USRT_B_OVERRUN_ERROR_FLAG] <= 1'b0;
			end
			if (rx_done) begin
				rxbuf <= rx_word[7:0];
				rxcs[`USRT_B_RECEIVED_NINTH_BIT] <= rx_word[8];
				if (rc_full && !rd_rxbuf)
					rxcs[`USRT_B_OVERRUN_ERROR_FLAG] <= 1'b1;
			end
			rxcs[`USRT_B_FRAMING_ERROR_FLAG] <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// read mux, answers in the access cycle
	// ----------------------------------------------------------------
	logic [7:0] rsel;
	always_comb begin
		case (paddr)
			`USRT_OFS_FLAGS: rsel = flags_r;
			`USRT_OFS_ENABLES: rsel = enables;
			`USRT_OFS_PRIORITY: rsel = priority_r;
			`USRT_OFS_RXCS: rsel = rxcs;
			`USRT_OFS_TXBUF: rsel = txbuf;
			`USRT_OFS_TXCS: rsel = txcs;
			`USRT_OFS_BAUD: rsel = baud;
			`USRT_OFS_RXBUF: rsel = rxbuf;
			`USRT_OFS_SLEEP: rsel = {7'd0, sleep_r};
			default: rsel = 8'h00;
		endcase
	end
	// pready comes from a flop: one wait state per access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			prdata <= {24'h00_0000, rsel};
			pslverr <= psel & penable & ~pready & ~mapped;
		end
	end
	// ----------------------------------------------------------------
	// interrupt and wake
	// ----------------------------------------------------------------
	wire req = (flags_r[`USRT_B_TX] & enables[`USRT_B_TX])
		| (flags_r[`USRT_B_RC] & enables[`USRT_B_RC]);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
			wake <= 1'b0;
			ser_data_oe <= 1'b0;
		end else begin
			irq <= req;
			wake <= req & sleep_r;
			ser_data_oe <= serial_port_enable & transmit_enable;
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_tx_irq;
		@(posedge clk) disable iff (!arst_n) irq |-> $past(enables[`USRT_B_TX] | enables[`USRT_B_RC]);
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("irq without enable");
	property p_load_flag;
		@(posedge clk) disable iff (!arst_n) load |=> flags_r[`USRT_B_TX] && !buf_full;
	endproperty
	a_load_flag: assert property (p_load_flag) else $error("load did not set flag");
	property p_start_low;
		@(posedge clk) disable iff (!arst_n) (load && !sync_mode) |=> !ser_data_out;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_idle_high;
		@(posedge clk) disable iff (!arst_n) (!tx_active && !sync_mode) |=> ser_data_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle high");
	property p_sleep_halt;
		@(posedge clk) disable iff (!arst_n) sleep_r |-> !brg_tick;
	endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("baud ran in sleep");
	property p_transmit_enable_flag;
		@(posedge clk) disable iff (!arst_n) transmit_enable_rise |=> flags_r[`USRT_B_TX];
	endproperty
	a_transmit_enable_flag: assert property (p_transmit_enable_flag) else $error("tx enable left flag clear");
	property p_rx_flag;
		@(posedge clk) disable iff (!arst_n) rx_done |=> flags_r[`USRT_B_RC];
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag missed");
	property p_wr_clear;
		@(posedge clk) disable iff (!arst_n) (wr_txbuf && !set_tx) |=> !flags_r[`USRT_B_TX] && buf_full;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("buffer write did not clear flag");
	// shift-empty lags the state by two edges: one for tsr_empty, one for the register
	sequence s_shift_empty_status_low;
		##1 !txcs[`USRT_B_SHIFT_EMPTY_STATUS];
	endsequence
	property p_shift_empty_status_busy;
		@(posedge clk) disable iff (!arst_n) (st != TX_IDLE) |=> s_shift_empty_status_low;
	endproperty
	a_shift_empty_status_busy: assert property (p_shift_empty_status_busy) else $error("shift-empty set while busy");
	// in slave mode each falling shift clock puts out the next low bit
	property p_sync_bit;
		@(posedge clk) disable iff (!arst_n)
			(tx_active && slave_shift && st == TX_DATA) |=> ser_data_out == $past(transmit_shift_register[0]);
	endproperty
	a_sync_bit: assert property (p_sync_bit) else $error("slave bit order wrong");
	// dropping continuous receive must clear a pending overrun
	property p_err_clear;
		@(posedge clk) disable iff (!arst_n)
			(wr_rxcs && !pwdata[`USRT_B_CONTINUOUS_RECEIVE_ENABLE] && !rx_done) |=> !rxcs[`USRT_B_OVERRUN_ERROR_FLAG];
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("overrun not cleared");
endmodule : usrt_core
`default_nettype wire

// ==== rtl/usrt_pkg.sv ====
// Purpose: shared types for the serial port block
// Assumes: nothing
// Notes: types only
package usrt_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usrt_tx_e;
	typedef struct packed {
		logic [8:0] data;
		logic nine;
	} usrt_word_s;
endpackage : usrt_pkg
